// ### core/elm_params.svh
// Offsets, reset values, field positions and counts of the lock monitor
`ifndef ELM_PARAMS_SVH
`define ELM_PARAMS_SVH
`define ELM_A_OVR      8'h00
`define ELM_A_STAT     8'h04
`define ELM_A_INT      8'h08
`define ELM_A_BND      8'h0C
`define ELM_A_DCTL     8'h10
`define ELM_A_ASYM     8'h14
`define ELM_A_JIT      8'h18
`define ELM_A_AVG      8'h1C
`define ELM_OVR_RST    6'h00
`define ELM_INT_RST    8'h40
`define ELM_BND_RST    16'hFF00
`define ELM_DCTL_RST   2'h2
`define ELM_STAT_LONG  2
`define ELM_WIN_LO     10'h24B
`define ELM_SYNC_D     10'h24C
`define ELM_WIN_HI     10'h24D
`define ELM_WIN_OV     10'h24E
`define ELM_OMISS_N    3'h7
`define ELM_LSAT16     6'h10
`define ELM_LSAT61     6'h3D
`define ELM_RL_MIN     4'h3
`define ELM_RL_SYNC    4'hB
`define ELM_RL_LONG    4'hE
`define ELM_C_LOCK     5'h01
`define ELM_C_INNER    5'h06
`define ELM_C_OUTER    5'h04
`define ELM_C_HOLD     5'h08
`define ELM_C_OUT3     5'h14
`define ELM_STEP_C     10'h008
`define ELM_STEP_F     10'h002
`define ELM_STEP_I     10'h002
`define ELM_STEP_L     10'h001
`define ELM_JT_1       4'h2
`define ELM_JT_2       4'h4
`define ELM_JT_3       4'h6
`define ELM_JV_0       6'h01
`define ELM_JV_1       6'h09
`define ELM_JV_2       6'h19
`define ELM_JV_3       6'h31
`define ELM_TBIT_LAST  2'h3
`define ELM_T_J1       6'h00
`define ELM_T_F        6'h0C
`define ELM_T_A        6'h18
`define ELM_T_J2       6'h24
`define ELM_T_PAUSE    6'h2F
`define ELM_DIV_SH     23
`endif

// ### core/elm_pkg.sv
// Types shared by the lock monitor
package elm_pkg;
  typedef enum logic [2:0] {
    MD_OUTER = 3'b000,
    MD_OUT3  = 3'b001,
    MD_HOLD  = 3'b010,
    MD_INNER = 3'b011,
    MD_LOCK  = 3'b100
  } elm_mode_t;
  typedef struct packed {
    logic [3:0] len;
    logic [3:0] lead_d;
    logic [3:0] trail_d;
  } elm_sym_t;
  typedef struct packed {
    logic       lock_override_enable;
    logic [4:0] forced_lock_state_code;
  } elm_ovr_t;
  typedef struct packed {
    logic [7:0] integrator_upper_bound;
    logic [7:0] integrator_lower_bound;
  } elm_bnd_t;
endpackage

// ### core/elm_lock_monitor.sv
// Loop lock control, pushback, jitter monitor and telemetry output
//
// Notes on behaviour
// (RL1) Three lock conditions: in-lock, inner aid, outer aid.
// (RL2) Outer aid goes inner on sync 587..589 apart; seven out-of-window syncs drop back.
// (RL3) Inner aid goes in-lock on sync 587..589 apart.
// (RL4) Missed syncs in lock counted, saturation at 16 or 61 leaves lock.
// (RL5) Status shows frequency lock, phase lock and overlong run flags.
// (RL6) Automatic capture mode chosen from the two lock flags.
// (RL7) Outer aid steers coarse on short runs, fine on long runs.
// (RL8) Inner aid steers towards exactly 588 bits between syncs.
// (RL9) Override forces in-lock, inner or outer by state code.
// (RL10) Override codes for hold and short-run-only outer; others reserved.
// (RL11) Without override, software state kept unless hardware is closer.
// (RL12) Hold freezes the frequency; a preset may still be written.
// (RL13) Integrator write presets frequency; read gives live value.
// (RL14) Integrator kept between lower and upper bound fields.
// (RL15) Pushback turns run lengths 1 and 2 into 3.
// (RL16) Slicer asymmetry readable as 8-bit two's complement.
// (RL17) Transition distance mapped to jitter inputs 1, 9, 25, 49.
// (RL18) Jitter averaged in 10-bit low-pass, upper 8 bits readable.
// (RL19) Long-term jitter averaged over 8000 bit clocks.
// (RL20) Telemetry frames of 64 bits, four clocks each, 17 pause bits.
// (RL21) Frame: start, jitter, start, frequency, start, asymmetry.
// (RL22) Frame tail: zeros, start, second jitter, pause.
// (RL23) Two successive run-length-11 symbols give a sync.
// (RL24) Frames back to back, each field sampled at its start.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "elm_params.svh"
module elm_lock_monitor
  import elm_pkg::*;
#(
  parameter int AVG_WIN = 8000
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Recovered bit clock
  input  wire logic        bclk_i,
  // Run-length symbols and transitions
  input  wire logic        sym_vld_i,
  input  wire elm_sym_t    sym_i,
  input  wire logic        zx_vld_i,
  input  wire logic [3:0]  zx_dist_i,
  input  wire logic        zx_late_i,
  input  wire logic [7:0]  asym_i,
  // Corrected symbols and lock state
  output logic             pb_vld_o,
  output logic      [3:0]  pb_len_o,
  output logic             pb_shift_late_o,
  output logic             sync_o,
  output elm_mode_t        mode_o,
  // Telemetry
  output logic             telemetry_out_pin_o,
  output logic             telemetry_sample_clock_o
);

  localparam logic [23:0] RECIP =
    24'((2 ** `ELM_DIV_SH + AVG_WIN / 2) / AVG_WIN);
  localparam logic [15:0] WIN_LAST = 16'(AVG_WIN - 1);

  // Saturating step of the integrator
  function automatic logic [9:0] fstep(logic [9:0] v, logic up,
                                       logic [9:0] a);
    logic [10:0] s;
    s = up ? {1'b0, v} + {1'b0, a} : {1'b0, v} - {1'b0, a};
    if (s[10]) fstep = up ? 10'h3FF : 10'h000;
    else fstep = s[9:0];
  endfunction

  // Limit to the programmed bounds
  function automatic logic [9:0] fclamp(logic [9:0] v, elm_bnd_t b);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = {b.integrator_lower_bound, 2'b00};
    hi = {b.integrator_upper_bound, 2'b11};
    if (v < lo) fclamp = lo;
    else if (v > hi) fclamp = hi;
    else fclamp = v;
  endfunction

  // Transition distance to jitter input
  function automatic logic [5:0] jit_map(logic [3:0] d);
    if (d < `ELM_JT_1) jit_map = `ELM_JV_0;
    else if (d < `ELM_JT_2) jit_map = `ELM_JV_1;
    else if (d < `ELM_JT_3) jit_map = `ELM_JV_2;
    else jit_map = `ELM_JV_3;
  endfunction

  logic        bclk_s1_q, bclk_s2_q, bclk_s3_q;
  elm_ovr_t    ovr_q;
  elm_bnd_t    bnd_q;
  logic        lock61_q, pben_q, long_q;
  logic [7:0]  asym_q;
  logic [31:0] rdata_q;
  logic        rl11_q;
  logic [9:0]  dist_q, dist_d;
  logic        frequency_lock_flag_q, frequency_lock_flag_d, phase_lock_flag_q, phase_lock_flag_d;
  logic [2:0]  omiss_q, omiss_d;
  logic [5:0]  lmiss_q, lmiss_d;
  logic [9:0]  freq_q, freq_d, f_nx;
  elm_mode_t   mode, sw_mode, mode_q;
  logic        sw_vld;
  logic        pb_vld_q, pb_shl_q;
  logic [3:0]  pb_len_q;
  logic        sync_q;
  logic [9:0]  acc_q, acc_d;
  logic [15:0] win_q;
  logic [23:0] sum_q;
  logic [7:0]  avg_q;
  logic [1:0]  tdiv_q;
  logic [5:0]  tidx_q;
  logic [9:0]  tj1_q, tf_q, tj2_q;
  logic [7:0]  ta_q;
  logic        telemetry_out_pin_q, tcl_q;

  // Bit clock synchroniser and edge find
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
    end else begin
      bclk_s1_q <= bclk_i;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
    end
  end
  wire bit_tick = bclk_s2_q & ~bclk_s3_q;

  // Register decode
  wire wr_ovr  = wr_i && (addr_i == `ELM_A_OVR);
  wire wr_stat = wr_i && (addr_i == `ELM_A_STAT);
  wire wr_int  = wr_i && (addr_i == `ELM_A_INT);
  wire wr_bnd  = wr_i && (addr_i == `ELM_A_BND);
  wire wr_dctl = wr_i && (addr_i == `ELM_A_DCTL);
  wire long_clr = wr_stat && wdata_i[`ELM_STAT_LONG];
  wire long_set = sym_vld_i && (sym_i.len >= `ELM_RL_LONG);

  // Software registers, overlong flag set wins over clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovr_q    <= `ELM_OVR_RST;
      bnd_q    <= `ELM_BND_RST;
      {pben_q, lock61_q} <= `ELM_DCTL_RST;
      long_q   <= 1'b0;
      asym_q   <= 8'h00;
    end else begin
      if (wr_ovr) ovr_q <= elm_ovr_t'(wdata_i[5:0]);
      if (wr_bnd) bnd_q <= elm_bnd_t'(wdata_i[15:0]);
      if (wr_dctl) {pben_q, lock61_q} <= wdata_i[1:0];
      long_q <= long_set | (long_q & ~long_clr); // RL5
      asym_q <= asym_i;
    end
  end

  // Read mux
  wire [31:0] rd_mux =
    (addr_i == `ELM_A_OVR)  ? {26'h0, ovr_q} :
    (addr_i == `ELM_A_STAT) ? {25'h0, mode_q, 1'b0, long_q,
                               phase_lock_flag_q, frequency_lock_flag_q} : // RL5
    (addr_i == `ELM_A_INT)  ? {24'h0, freq_q[9:2]} : // RL13
    (addr_i == `ELM_A_BND)  ? {16'h0, bnd_q} :
    (addr_i == `ELM_A_DCTL) ? {30'h0, pben_q, lock61_q} :
    (addr_i == `ELM_A_ASYM) ? {24'h0, asym_q} : // RL16
    (addr_i == `ELM_A_JIT)  ? {24'h0, acc_q[9:2]} : // RL18
    (addr_i == `ELM_A_AVG)  ? {24'h0, avg_q} : 32'h0;

  // Read data for one cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_q <= 32'h0;
    else rdata_q <= rd_i ? rd_mux : 32'h0;
  end
  assign rdata_o = rdata_q;

  // Sync detection and distance count
  wire sync_det = sym_vld_i && (sym_i.len == `ELM_RL_SYNC) && rl11_q; // RL23
  wire in_win = (dist_q >= `ELM_WIN_LO) && (dist_q <= `ELM_WIN_HI);
  wire sync_ok  = sync_det && in_win;
  wire sync_bad = sync_det && !in_win;
  wire miss_ev  = bit_tick && (dist_q == `ELM_WIN_OV) && !sync_det;
  assign dist_d = sync_det ? {9'h000, bit_tick} :
                  miss_ev ? (`ELM_WIN_OV - `ELM_SYNC_D) :
                  dist_q + {9'h000, bit_tick};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rl11_q <= 1'b0;
      dist_q <= 10'h000;
      sync_q <= 1'b0;
    end else begin
      if (sym_vld_i) rl11_q <= (sym_i.len == `ELM_RL_SYNC) && !sync_det;
      dist_q <= dist_d;
      sync_q <= sync_det;
    end
  end

  // Lock flags and miss counters
  wire [5:0] lsat = lock61_q ? `ELM_LSAT61 : `ELM_LSAT16;
  always_comb begin
    frequency_lock_flag_d  = frequency_lock_flag_q;
    phase_lock_flag_d = phase_lock_flag_q;
    omiss_d  = omiss_q;
    lmiss_d  = lmiss_q;
    if (phase_lock_flag_q) begin
      if (sync_ok) lmiss_d = 6'h00;
      else if (sync_bad || miss_ev) begin
        if (lmiss_q == 6'(lsat - 6'h01)) begin // RL4
          phase_lock_flag_d = 1'b0;
          lmiss_d  = 6'h00;
        end else lmiss_d = lmiss_q + 6'h01;
      end
    end else if (frequency_lock_flag_q) begin
      if (sync_ok) begin // RL3
        phase_lock_flag_d = 1'b1;
        omiss_d  = 3'h0;
      end else if (sync_bad) begin
        if (omiss_q == 3'(`ELM_OMISS_N - 3'h1)) begin // RL2
          frequency_lock_flag_d = 1'b0;
          omiss_d = 3'h0;
        end else omiss_d = omiss_q + 3'h1;
      end
    end else if (sync_ok) begin // RL2
      frequency_lock_flag_d = 1'b1;
      omiss_d = 3'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frequency_lock_flag_q  <= 1'b0;
      phase_lock_flag_q <= 1'b0;
      omiss_q  <= 3'h0;
      lmiss_q  <= 6'h00;
    end else begin
      frequency_lock_flag_q  <= frequency_lock_flag_d;
      phase_lock_flag_q <= phase_lock_flag_d;
      omiss_q  <= omiss_d;
      lmiss_q  <= lmiss_d;
    end
  end

  // Hardware mode from the flags
  wire elm_mode_t hw_mode = phase_lock_flag_q ? MD_LOCK :
                            frequency_lock_flag_q ? MD_INNER : MD_OUTER; // RL6 RL1

  // Software state code decode
  always_comb begin
    sw_vld  = 1'b1;
    sw_mode = MD_OUTER;
    unique case (ovr_q.forced_lock_state_code)
      `ELM_C_LOCK:  sw_mode = MD_LOCK; // RL9
      `ELM_C_INNER: sw_mode = MD_INNER; // RL9
      `ELM_C_OUTER: sw_mode = MD_OUTER; // RL9
      `ELM_C_HOLD:  sw_mode = MD_HOLD; // RL10
      `ELM_C_OUT3:  sw_mode = MD_OUT3; // RL10
      default:      sw_vld = 1'b0; // RL10
    endcase
  end

  // Effective mode: forced, or the closer of software and hardware
  wire ovr_act = ovr_q.lock_override_enable && sw_vld;
  wire sw_wins = !ovr_q.lock_override_enable && sw_vld &&
                 (sw_mode > hw_mode); // RL11
  assign mode = (ovr_act || sw_wins) ? sw_mode : hw_mode;

  // Frequency steering per mode
  wire short_rl = sym_vld_i && (sym_i.len < `ELM_RL_MIN);
  wire long_rl  = sym_vld_i && (sym_i.len > `ELM_RL_SYNC);
  always_comb begin
    f_nx = freq_q;
    unique case (mode)
      MD_OUTER, MD_OUT3: begin
        if (short_rl) f_nx = fstep(freq_q, 1'b1, `ELM_STEP_C); // RL7
        else if (long_rl && mode == MD_OUTER)
          f_nx = fstep(freq_q, 1'b0, `ELM_STEP_F); // RL7
      end
      MD_INNER: begin
        if (sync_det && dist_q != `ELM_SYNC_D)
          f_nx = fstep(freq_q, dist_q < `ELM_SYNC_D,
                       `ELM_STEP_I); // RL8
      end
      MD_LOCK: begin
        if (zx_vld_i && zx_dist_i >= `ELM_JT_1)
          f_nx = fstep(freq_q, !zx_late_i, `ELM_STEP_L);
      end
      MD_HOLD: f_nx = freq_q; // RL12
    endcase
  end
  assign freq_d = wr_int ? fclamp({wdata_i[7:0], 2'b00}, bnd_q) : // RL13
                  (mode == MD_HOLD) ? freq_q : // RL12
                  fclamp(f_nx, bnd_q); // RL14

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      freq_q <= {`ELM_INT_RST, 2'b00};
      mode_q <= MD_OUTER;
    end else begin
      freq_q <= freq_d;
      mode_q <= mode;
    end
  end

  // Run length pushback
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pb_vld_q <= 1'b0;
      pb_len_q <= 4'h0;
      pb_shl_q <= 1'b0;
    end else begin
      pb_vld_q <= sym_vld_i;
      if (sym_vld_i) begin
        pb_len_q <= (pben_q && sym_i.len < `ELM_RL_MIN) ?
                    `ELM_RL_MIN : sym_i.len; // RL15
        pb_shl_q <= pben_q && (sym_i.len == 4'h2) &&
                    (sym_i.trail_d >= sym_i.lead_d); // RL15
      end
    end
  end

  // Jitter low-pass filter
  assign acc_d = zx_vld_i ? acc_q - {4'h0, acc_q[9:4]} +
                 {4'h0, jit_map(zx_dist_i)} : acc_q; // RL17 RL18

  // Long-term average over a window of bit clocks
  wire [23:0] sum_nx = sum_q + {16'h0, acc_q[9:2]};
  wire [47:0] prod = sum_nx * RECIP;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= 10'h000;
      win_q <= 16'h0000;
      sum_q <= 24'h00_0000;
      avg_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
      if (bit_tick) begin
        if (win_q == WIN_LAST) begin // RL19
          win_q <= 16'h0000;
          sum_q <= 24'h00_0000;
          avg_q <= prod[`ELM_DIV_SH+7:`ELM_DIV_SH];
        end else begin
          win_q <= win_q + 16'h0001;
          sum_q <= sum_nx;
        end
      end
    end
  end

  // Telemetry frame, bit 0 at the top
  wire [63:0] frame = {1'b1, tj1_q, 1'b0, 1'b1, tf_q, 1'b0,
                       1'b1, ta_q, 3'b000, 1'b1, tj2_q,
                       17'h0_0000}; // RL21 RL22
  wire tstart = (tdiv_q == 2'b00);

  // Telemetry timing, capture and output
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdiv_q <= 2'b00;
      tidx_q <= 6'h00;
      tj1_q  <= 10'h000;
      tf_q   <= 10'h000;
      ta_q   <= 8'h00;
      tj2_q  <= 10'h000;
      telemetry_out_pin_q <= 1'b0;
      tcl_q  <= 1'b0;
    end else begin
      tdiv_q <= tdiv_q + 2'b01;
      if (tdiv_q == `ELM_TBIT_LAST) tidx_q <= tidx_q + 6'h01; // RL20 RL24
      if (tstart && tidx_q == `ELM_T_J1) tj1_q <= acc_q; // RL24
      if (tstart && tidx_q == `ELM_T_F) tf_q <= freq_q;
      if (tstart && tidx_q == `ELM_T_A) ta_q <= asym_q;
      if (tstart && tidx_q == `ELM_T_J2) tj2_q <= acc_q;
      telemetry_out_pin_q <= frame[6'(6'h3F - tidx_q)];
      tcl_q  <= tdiv_q[1];
    end
  end

  assign pb_vld_o = pb_vld_q;
  assign pb_len_o = pb_len_q;
  assign pb_shift_late_o = pb_shl_q;
  assign sync_o = sync_q;
  assign mode_o = mode_q;
  assign telemetry_out_pin_o = telemetry_out_pin_q;
  assign telemetry_sample_clock_o = tcl_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_outer_win;
    !frequency_lock_flag_q && sync_ok |=> frequency_lock_flag_q && !phase_lock_flag_q;
  endproperty
  a_outer_win: assert property (p_outer_win) // RL2
    else $error("outer aid did not move to inner on window sync");

  property p_omiss;
    frequency_lock_flag_q && !phase_lock_flag_q && sync_bad && omiss_q == 3'h6 |=> !frequency_lock_flag_q;
  endproperty
  a_omiss: assert property (p_omiss) // RL2
    else $error("seventh bad sync did not leave inner aid");

  property p_inner_lock;
    frequency_lock_flag_q && !phase_lock_flag_q && sync_ok |=> phase_lock_flag_q;
  endproperty
  a_inner_lock: assert property (p_inner_lock) // RL3
    else $error("inner aid did not lock on window sync");

  property p_lsat;
    phase_lock_flag_q && !sync_ok && (sync_bad || miss_ev) &&
    lmiss_q == 6'(lsat - 6'h01) |=> !phase_lock_flag_q && frequency_lock_flag_q;
  endproperty
  a_lsat: assert property (p_lsat) // RL4
    else $error("miss saturation did not leave lock");

  property p_long;
    long_set |=> long_q ##1 (long_q || $past(long_clr));
  endproperty
  a_long: assert property (p_long) // RL5
    else $error("overlong flag lost");

  property p_hold;
    mode == MD_HOLD && !wr_int |=> $stable(freq_q);
  endproperty
  a_hold: assert property (p_hold) // RL12
    else $error("frequency moved in hold");

  property p_bounds;
    $stable(bnd_q) && $past(mode) != MD_HOLD &&
    bnd_q.integrator_lower_bound <= bnd_q.integrator_upper_bound |->
    freq_q[9:2] >= bnd_q.integrator_lower_bound &&
    freq_q[9:2] <= bnd_q.integrator_upper_bound;
  endproperty
  a_bounds: assert property (p_bounds) // RL14
    else $error("integrator outside bounds");

  property p_push;
    pben_q && short_rl |=> pb_vld_o && pb_len_o == 4'h3;
  endproperty
  a_push: assert property (p_push) // RL15
    else $error("short run not pushed back");

  property p_jit;
    zx_vld_i && zx_dist_i >= `ELM_JT_3 |=>
    acc_q == 10'($past(acc_q) - ($past(acc_q) >> 4) + 10'h031);
  endproperty
  a_jit: assert property (p_jit) // RL17
    else $error("wrong jitter input");

  property p_pause;
    tidx_q >= `ELM_T_PAUSE |=> !telemetry_out_pin_o;
  endproperty
  a_pause: assert property (p_pause) // RL20
    else $error("pause bit not zero");

  property p_start;
    tidx_q == 6'h00 && tdiv_q == 2'b01 |-> telemetry_out_pin_o;
  endproperty
  a_start: assert property (p_start) // RL21
    else $error("start bit missing");

  c_lock: cover property (!phase_lock_flag_q ##1 phase_lock_flag_q);
  c_unlock: cover property (phase_lock_flag_q ##1 !phase_lock_flag_q);
  c_hold: cover property (mode == MD_HOLD && wr_int);
  c_frame: cover property (tidx_q == 6'h3F ##4 tidx_q == 6'h00);

endmodule

// ### sim/elm_telemetry_out_pin_rx.sv
// Telemetry receiver model that decodes frames from the measurement pin
`timescale 1ns/1ps
module elm_telemetry_out_pin_rx (
  // Clock and observed pins
  input  wire logic        clk_i,
  input  wire logic        pin_i,
  input  wire logic        sclk_i,
  // Decoded frame, bit i of the frame at index i
  output logic      [63:0] frame_o,
  output logic             frame_vld_o
);
  logic       sclk_q = 1'b0;
  logic       busy_q = 1'b0;
  logic [5:0] idx_q  = 6'h00;
  logic [4:0] zero_q = 5'h00;
  initial frame_vld_o = 1'b0;
  // Sample on each rise of the sample clock, start needs 17 zeros first
  always @(posedge clk_i) begin
    sclk_q      <= sclk_i;
    frame_vld_o <= 1'b0;
    if (sclk_i && !sclk_q) begin
      if (pin_i) zero_q <= 5'h00;
      else if (zero_q != 5'h1F) zero_q <= zero_q + 5'h01;
      if (busy_q) begin
        frame_o[idx_q] <= pin_i;
        idx_q          <= idx_q + 6'h01;
        if (idx_q == 6'h3F) begin
          busy_q      <= 1'b0;
          frame_vld_o <= 1'b1;
        end
      end else if (pin_i && zero_q >= 5'h11) begin
        busy_q     <= 1'b1;
        frame_o[0] <= 1'b1;
        idx_q      <= 6'h01;
      end
    end
  end
endmodule

// ### sim/test_elm_lock_monitor.sv
// Self-checking bench of the lock monitor
`timescale 1ns/1ps
`include "elm_params.svh"
module test_elm_lock_monitor
  import elm_pkg::*;
;
  logic        clk_i, resetn_i, wr, rd, bclk, sym_vld, zx_vld, zx_late;
  logic        pb_vld, pb_late, sync, tpin, tsclk, fvld;
  logic [7:0]  addr, asym, ival;
  logic [31:0] wdata, rdata, rv, rw;
  logic [3:0]  zx_dist, pb_len, l;
  logic [15:0] seed;
  logic [63:0] frame, fexp;
  elm_sym_t    sym;
  elm_mode_t   mode;
  int          err_total, checked, bcnt, bref;
  realtime     t1;
  logic [4:0]  codes [6] = '{5'h01, 5'h06, 5'h04, 5'h08, 5'h14, 5'h03};
  elm_mode_t   mexp [6]  = '{MD_LOCK, MD_INNER, MD_OUTER, MD_HOLD,
                             MD_OUT3, MD_OUTER};
  logic [3:0]  jd [4]    = '{4'h1, 4'h3, 4'h5, 4'h7};
  logic [9:0]  jv [4]    = '{10'h001, 10'h009, 10'h019, 10'h031};

  elm_lock_monitor #(.AVG_WIN(16)) u_elm_lock_monitor (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bclk_i(bclk),
    .sym_vld_i(sym_vld), .sym_i(sym), .zx_vld_i(zx_vld),
    .zx_dist_i(zx_dist), .zx_late_i(zx_late), .asym_i(asym),
    .pb_vld_o(pb_vld), .pb_len_o(pb_len), .pb_shift_late_o(pb_late),
    .sync_o(sync), .mode_o(mode), .telemetry_out_pin_o(tpin),
    .telemetry_sample_clock_o(tsclk));
  elm_telemetry_out_pin_rx u_elm_telemetry_out_pin_rx (.clk_i(clk_i), .pin_i(tpin), .sclk_i(tsclk),
    .frame_o(frame), .frame_vld_o(fvld));

  // System clock and free-running bit clock of unrelated phase
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    bclk = 1'b0;
    #3.3;
    forever #62.5 bclk = ~bclk;
  end
  initial bcnt = 0;
  always @(posedge bclk) bcnt <= bcnt + 1;

  // Expected values
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  function automatic logic [31:0] jexp(input logic [9:0] v);
    return 32'((v * 16) >> 2);
  endfunction
  function automatic logic [63:0] fexp_f(input logic [9:0] j,
      input logic [9:0] f, input logic [7:0] a);
    logic [63:0] r;
    r = '0;
    r[0] = 1'b1;
    r[12] = 1'b1;
    r[24] = 1'b1;
    r[36] = 1'b1;
    for (int i = 0; i < 10; i++) begin
      r[1 + i] = j[9 - i];
      r[13 + i] = f[9 - i];
      r[37 + i] = j[9 - i];
    end
    for (int i = 0; i < 8; i++) r[25 + i] = a[7 - i];
    return r;
  endfunction

  // Comparison, timeout and verdict
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("Counts: %0d checked, %0d errors", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input bit hit);
    if (hit) begin
      err_total++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      results();
    end
  endtask

  // Register port cycles
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Symbol, sync, transition and frame helpers
  task automatic put(input logic [3:0] n, input logic [3:0] a,
      input logic [3:0] b);
    int c;
    @(posedge clk_i);
    sym_vld <= 1'b1;
    sym     <= '{len: n, lead_d: a, trail_d: b};
    @(posedge clk_i);
    sym_vld <= 1'b0;
    #1;
    for (c = 0; c < 4 && pb_vld !== 1'b1; c++) @(posedge clk_i) #1;
    tmo(c == 4);
  endtask
  task automatic send_sync();
    int c;
    put(4'hB, 4'h0, 4'h0);
    put(4'hB, 4'h0, 4'h0);
    for (c = 0; c < 6 && sync !== 1'b1; c++) @(posedge clk_i) #1;
    chk(sync, 1'b1);
    bref = bcnt;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic gap(input int n);
    int c;
    for (c = 0; c < n + 2 && bcnt < bref + n; c++) @(posedge bclk) #1;
    tmo(bcnt < bref + n);
    #60;
  endtask
  task automatic zx(input logic [3:0] d, input int n);
    repeat (n) begin
      seed = lfsr(seed);
      @(posedge clk_i);
      zx_vld  <= 1'b1;
      zx_dist <= d;
      zx_late <= seed[0];
      @(posedge clk_i);
      zx_vld <= 1'b0;
    end
  endtask
  task automatic wait_frame();
    int c;
    for (c = 0; c < 400 && fvld !== 1'b1; c++) @(posedge clk_i) #1;
    tmo(c == 400);
    @(posedge clk_i) #1;
  endtask

  // Main sequence
  initial begin
    {resetn_i, wr, rd, sym_vld, zx_vld, zx_late} = '0;
    {addr, wdata, zx_dist, sym, asym} = '0;
    seed = 16'h097F;
    err_total = 0;
    checked = 0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd_reg(`ELM_A_OVR, rv);  chk(rv, 32'h0000_0000);
    rd_reg(`ELM_A_BND, rv);  chk(rv, 32'h0000_FF00);
    rd_reg(`ELM_A_DCTL, rv); chk(rv, 32'h0000_0002);
    rd_reg(`ELM_A_INT, rv);  chk(rv, 32'h0000_0040);
    rd_reg(8'h20, rv);       chk(rv, 32'h0000_0000);
    // Every state code under override, a reserved one last
    for (int i = 0; i < 6; i++) begin
      wr_reg(`ELM_A_OVR, {26'h0, 1'b1, codes[i]});
      repeat (2) @(posedge clk_i);
      chk(mode, mexp[i]);
    end
    rd_reg(`ELM_A_STAT, rv); chk(rv[6:4], MD_OUTER);
    wr_reg(`ELM_A_OVR, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk(mode, MD_LOCK);
    wr_reg(`ELM_A_OVR, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk(mode, MD_OUTER);
    // Short-run steering and pushback
    rd_reg(`ELM_A_INT, rv);
    put(4'h2, 4'h1, 4'h1);
    rd_reg(`ELM_A_INT, rw); chk(rw, rv + 32'h2);
    put(4'h1, 4'h2, 4'h5); chk({pb_late, pb_len}, 5'h03);
    put(4'h2, 4'h2, 4'h5); chk({pb_late, pb_len}, 5'h13);
    put(4'h2, 4'h6, 4'h1); chk({pb_late, pb_len}, 5'h03);
    repeat (8) begin
      seed = lfsr(seed);
      l = 4'h3 + 4'(seed % 11);
      put(l, seed[7:4], seed[11:8]); chk({pb_late, pb_len}, {1'b0, l});
    end
    wr_reg(`ELM_A_DCTL, 32'h0000_0000);
    put(4'h2, 4'h2, 4'h5); chk({pb_late, pb_len}, 5'h02);
    rd_reg(`ELM_A_STAT, rv); chk(rv[2], 1'b0);
    put(4'hE, 4'h1, 4'h1);
    rd_reg(`ELM_A_STAT, rv); chk(rv[2], 1'b1);
    wr_reg(`ELM_A_STAT, 32'h0000_0004);
    rd_reg(`ELM_A_STAT, rv); chk(rv[2], 1'b0);
    // Hold, bounds and preset
    wr_reg(`ELM_A_BND, 32'h0000_5030);
    wr_reg(`ELM_A_OVR, 32'h0000_0028);
    wr_reg(`ELM_A_INT, 32'h0000_0070);
    rd_reg(`ELM_A_INT, rv); chk(rv, 32'h0000_0050);
    wr_reg(`ELM_A_INT, 32'h0000_0010);
    rd_reg(`ELM_A_INT, rv); chk(rv, 32'h0000_0030);
    seed = lfsr(seed);
    ival = 8'h30 + 8'(seed % 33);
    wr_reg(`ELM_A_INT, {24'h0, ival});
    rd_reg(`ELM_A_INT, rv); chk(rv, {24'h0, ival});
    @(posedge clk_i) asym <= seed[15:8];
    repeat (3) @(posedge clk_i);
    rd_reg(`ELM_A_ASYM, rv); chk(rv[7:0], asym);
    // Jitter classes in rising order, filter settles on each
    for (int i = 0; i < 4; i++) begin
      zx(jd[i], 200);
      rd_reg(`ELM_A_JIT, rv); chk(rv, jexp(jv[i]));
    end
    repeat (40) @(posedge bclk);
    rd_reg(`ELM_A_AVG, rv); chk(rv, jexp(jv[3]));
    rd_reg(`ELM_A_INT, rv); chk(rv, {24'h0, ival});
    // Telemetry frames, back to back
    fexp = fexp_f(10'h310, {ival, 2'b00}, asym);
    wait_frame();
    wait_frame();
    chk(frame, fexp);
    t1 = $realtime;
    wait_frame();
    chk(frame, fexp);
    chk(longint'($realtime - t1), 64'h0000_0000_0000_0A00);
    // Automatic lock acquisition and loss, from a fresh reset
    @(posedge clk_i) resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd_reg(`ELM_A_OVR, rv); chk(rv, 32'h0000_0000);
    wr_reg(`ELM_A_OVR, 32'h0000_0000);
    send_sync();
    gap(588);
    send_sync(); chk(mode, MD_INNER);
    rd_reg(`ELM_A_STAT, rv); chk(rv[1:0], 2'b01);
    gap(588);
    send_sync(); chk(mode, MD_LOCK);
    rd_reg(`ELM_A_STAT, rv); chk(rv[1], 1'b1);
    for (int k = 1; k <= 16; k++) begin
      gap(100);
      send_sync(); chk(mode, k < 16 ? MD_LOCK : MD_INNER);
    end
    for (int k = 1; k <= 7; k++) begin
      gap(100);
      send_sync(); chk(mode, k < 7 ? MD_INNER : MD_OUTER);
    end
    results();
  end
endmodule
